//--- rtl/boot_cfg_regs.vh
// Constants for the reset-time boot configuration block.
// Assumes inclusion by bare name from rtl/ design files.
`ifndef BOOT_CFG_REGS_VH
`define BOOT_CFG_REGS_VH
// Register indices on the local register port.
`define REG_PROC_MODE_STATUS 4'h0
`define REG_BOOT_STATUS      4'h1
`define REG_BOOT_SELECT      4'h2
// Processor mode status field positions.
`define PMS_MP_BIT           0
`define PMS_PON_BIT          1
`define PMS_DON_BIT          2
`define PMS_STYLE_BIT        3
`define PMS_FRDN_BIT         15
`define PMS_SARAM_RESET      2'h3
// I/O addresses used by the loader.
`define IO_BOOT_SELECT_ADDR  16'h0000
`define IO_PARALLEL_ADDR     16'h0001
// Program space regions.
`define ROM_TEST_BASE        16'h7f00
`define ROM_RESET_VECTOR     16'h0000
`define ROM_ALAW_BASE        16'h0400
`define ROM_MULAW_BASE       16'h0500
// Boot modes.
`define MODE_NONE            4'h0
`define MODE_LEGACY          4'h1
`define MODE_SSP8            4'h2
`define MODE_SSP16           4'h3
`define MODE_PAR8            4'h4
`define MODE_PAR16           4'h5
`define MODE_UART8           4'h6
`define MODE_EPROM8          4'h7
`define MODE_EPROM16         4'h8
`define MODE_WARM            4'h9
// Start address built from a six-bit field: field sits at these bits.
`define ADDR_FIELD_SHIFT     10
`endif

//--- rtl/reset_boot_mode_select.v
// Reset-time boot configuration: strap capture, program ROM mapping,
// boot-select word decode and parallel-port code load.
// Assumes straps are asynchronous pins; the I/O bus, register port and
// code sink all run on core_clk_in.
// Operation
// - ROM mapping follows status bit 0, loaded from the processor-mode strap at reset.
// - Strap low: internal ROM answers program fetches 0000 to 7eff.
// - Words 7f00 to 7fff are test-reserved and not served to applications.
// - Strap high: program addresses 0000 to 7fff go to external memory.
// - Strap low at reset: fetch starts in internal ROM at address zero, or at the entry field for warm boot.
// - Boot option comes from style strap plus word read at I/O zero.
// - Only the low eight bits of the boot-select word are decoded.
// - EPROM boot builds a source address, warm boot a start address, from a six-bit field.
// - Both strap levels are copied into the mode status register at reset.
// - Strap low: style low gives legacy mode 1, high gives modes 2 to 9, or 0 for an undecoded code.
// - Bits 3:2 pick 8/16-bit serial or 8/16-bit parallel when others zero.
// - Bit 4 set with bits 3:0 zero selects eight-bit UART load.
// - Bits 1:0 of 01 or 10 pick 8/16-bit EPROM with address field.
// - Bits 1:0 of 11 pick warm boot at the entry address field.
// - Parallel boot reads code words from I/O address one.
// - ROM holds A-law table at 0400 and mu-law table at 0500.
// - Status bit 0 latches the mode strap at reset and is writable.
// - Status bit 3 captures the style strap only at reset.
`timescale 1ns/1ps
`include "boot_cfg_regs.vh"
`default_nettype none

module reset_boot_mode_select #(
    parameter LOAD_WORDS  = 256,
    parameter TABLE_WORDS = 256
) (
    // Clock and reset.
    input  wire        core_clk_in,
    input  wire        srst_in,
    // Strap pins.
    input  wire        proc_mode_strap_in,
    input  wire        boot_style_strap_in,
    // Register port.
    input  wire [3:0]  reg_addr_in,
    input  wire [15:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [15:0] reg_rdata_out,
    // Program fetch decode.
    input  wire [15:0] prog_addr_in,
    input  wire        prog_fetch_in,
    output reg         rom_sel_out,
    output reg         ext_prog_sel_out,
    output reg         rom_reserved_hit_out,
    output reg         alaw_table_hit_out,
    output reg         mulaw_table_hit_out,
    // I/O read bus.
    output reg         io_rd_out,
    output reg  [15:0] io_addr_out,
    input  wire [15:0] io_rdata_in,
    input  wire        io_ack_in,
    // Code stream toward program memory.
    output reg  [15:0] code_data_out,
    output reg         code_valid_out,
    input  wire        code_ready_in,
    // Boot result.
    output reg  [3:0]  boot_mode_out,
    output reg  [15:0] boot_source_addr_out,
    output reg  [15:0] warm_entry_addr_out,
    output reg  [15:0] start_addr_out,
    output reg         start_from_rom_out,
    output reg         boot_done_out,
    output reg         boot_error_out
);

    ////////////////////////////////////////////////////////////////////
    // Strap synchronisers and capture.

    localparam [31:0] LOAD_LAST_W = LOAD_WORDS - 1;
    localparam [31:0] TBL_SPAN_W  = TABLE_WORDS;
    localparam [15:0] LOAD_LAST   = LOAD_LAST_W[15:0];
    localparam [15:0] TBL_SPAN    = TBL_SPAN_W[15:0];

    reg  [1:0]  mp_sync;
    reg  [1:0]  style_sync;
    reg         pms_mp;
    reg  [1:0]  pms_saram;
    reg         pms_style;
    reg         pms_frdn;
    wire        wr_pms;

    assign wr_pms = reg_wr_in && (reg_addr_in == `REG_PROC_MODE_STATUS);

    // Two-stage synchronisers; no reset so they settle while reset is held.
    always @(posedge core_clk_in) begin
        mp_sync    <= {mp_sync[0], proc_mode_strap_in};
        style_sync <= {style_sync[0], boot_style_strap_in};
    end

    // Status register: straps are caught on every edge while reset is high.
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            pms_mp    <= mp_sync[1];
            pms_style <= style_sync[1];
            pms_saram <= `PMS_SARAM_RESET;
            pms_frdn  <= 1'b0;
        end else if (wr_pms) begin
            pms_mp    <= reg_wdata_in[`PMS_MP_BIT];
            pms_saram <= {reg_wdata_in[`PMS_DON_BIT], reg_wdata_in[`PMS_PON_BIT]};
            pms_frdn  <= reg_wdata_in[`PMS_FRDN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Program space decode, registered one cycle after the fetch.

    wire low_half;
    wire in_test;
    wire in_alaw;
    wire in_mulaw;

    assign low_half = ~prog_addr_in[15];
    assign in_test  = low_half && (prog_addr_in >= `ROM_TEST_BASE);
    assign in_alaw  = (prog_addr_in >= `ROM_ALAW_BASE) &&
                      (prog_addr_in < (`ROM_ALAW_BASE + TBL_SPAN));
    assign in_mulaw = (prog_addr_in >= `ROM_MULAW_BASE) &&
                      (prog_addr_in < (`ROM_MULAW_BASE + TBL_SPAN));

    // ROM answers only in microcomputer mode and never in the test area.
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            rom_sel_out          <= 1'b0;
            ext_prog_sel_out     <= 1'b0;
            rom_reserved_hit_out <= 1'b0;
            alaw_table_hit_out   <= 1'b0;
            mulaw_table_hit_out  <= 1'b0;
        end else begin
            rom_sel_out          <= prog_fetch_in && !pms_mp && low_half && !in_test;
            ext_prog_sel_out     <= prog_fetch_in && (pms_mp || !low_half);
            rom_reserved_hit_out <= prog_fetch_in && !pms_mp && in_test;
            alaw_table_hit_out   <= prog_fetch_in && !pms_mp && in_alaw;
            mulaw_table_hit_out  <= prog_fetch_in && !pms_mp && in_mulaw;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Two-entry code buffer: output stage plus one skid entry.

    reg  [15:0] skid_data;
    reg         skid_valid;
    reg         push;
    reg  [15:0] push_data;
    wire        buf_ready;

    assign buf_ready = ~skid_valid;

    // A stalled sink parks one word in the skid entry and closes the input.
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            code_valid_out <= 1'b0;
            code_data_out  <= 16'h0000;
            skid_valid     <= 1'b0;
            skid_data      <= 16'h0000;
        end else if (!code_valid_out || code_ready_in) begin
            if (skid_valid) begin
                code_valid_out <= 1'b1;
                code_data_out  <= skid_data;
                skid_valid     <= 1'b0;
            end else begin
                code_valid_out <= push;
                if (push) begin
                    code_data_out <= push_data;
                end
            end
        end else if (push) begin
            skid_valid <= 1'b1;
            skid_data  <= push_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Boot sequencer.

    localparam [6:0] ST_START  = 7'h01;
    localparam [6:0] ST_SELREQ = 7'h02;
    localparam [6:0] ST_SELWT  = 7'h04;
    localparam [6:0] ST_DECODE = 7'h08;
    localparam [6:0] ST_LDREQ  = 7'h10;
    localparam [6:0] ST_LDWT   = 7'h20;
    localparam [6:0] ST_DONE   = 7'h40;

    reg  [6:0]  state;
    reg  [6:0]  next_state;
    reg  [15:0] select_word;
    reg  [15:0] word_cnt;
    reg  [7:0]  hi_byte;
    reg         hi_have;
    reg  [3:0]  dec_mode;
    wire [7:0]  sel_low;
    wire [15:0] field_addr;
    wire        byte_mode;
    wire        last_word;

    assign sel_low    = select_word[7:0];
    assign field_addr = {sel_low[7:2], 10'h000};
    assign byte_mode  = (boot_mode_out == `MODE_PAR8);
    assign last_word  = (word_cnt == LOAD_LAST);

    // Mode decode of the low byte of the boot-select word.
    always @* begin
        dec_mode = `MODE_NONE;
        case (sel_low[1:0])
            2'b01: dec_mode = `MODE_EPROM8;
            2'b10: dec_mode = `MODE_EPROM16;
            2'b11: dec_mode = `MODE_WARM;
            default: begin
                if (sel_low[4]) begin
                    if (sel_low[3:2] == 2'b00) begin
                        dec_mode = `MODE_UART8;
                    end
                end else begin
                    case (sel_low[3:2])
                        2'b00:   dec_mode = `MODE_SSP8;
                        2'b01:   dec_mode = `MODE_SSP16;
                        2'b10:   dec_mode = `MODE_PAR8;
                        default: dec_mode = `MODE_PAR16;
                    endcase
                end
            end
        endcase
    end

    // Next state.
    always @* begin
        next_state = state;
        case (state)
            ST_START: begin
                if (pms_mp) begin
                    next_state = ST_DONE;
                end else if (pms_style) begin
                    next_state = ST_SELREQ;
                end else begin
                    next_state = ST_DONE;
                end
            end
            ST_SELREQ: next_state = ST_SELWT;
            ST_SELWT: begin
                if (io_ack_in) begin
                    next_state = ST_DECODE;
                end
            end
            ST_DECODE: begin
                if (dec_mode == `MODE_PAR8 || dec_mode == `MODE_PAR16) begin
                    next_state = ST_LDREQ;
                end else begin
                    next_state = ST_DONE;
                end
            end
            ST_LDREQ: begin
                if (buf_ready) begin
                    next_state = ST_LDWT;
                end
            end
            ST_LDWT: begin
                if (io_ack_in) begin
                    if (push && last_word) begin
                        next_state = ST_DONE;
                    end else begin
                        next_state = ST_LDREQ;
                    end
                end
            end
            ST_DONE: next_state = ST_DONE;
            default: next_state = ST_START;
        endcase
    end

    // Word assembly: an eight-bit port gives high byte first, then low.
    always @* begin
        push      = 1'b0;
        push_data = io_rdata_in;
        if (state == ST_LDWT && io_ack_in) begin
            if (byte_mode) begin
                push      = hi_have;
                push_data = {hi_byte, io_rdata_in[7:0]};
            end else begin
                push      = 1'b1;
            end
        end
    end

    // Sequencer registers and I/O strobes.
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            state       <= ST_START;
            io_rd_out   <= 1'b0;
            io_addr_out <= `IO_BOOT_SELECT_ADDR;
            select_word <= 16'h0000;
            word_cnt    <= 16'h0000;
            hi_byte     <= 8'h00;
            hi_have     <= 1'b0;
        end else begin
            state     <= next_state;
            io_rd_out <= 1'b0;
            if (state == ST_SELREQ) begin
                io_rd_out   <= 1'b1;
                io_addr_out <= `IO_BOOT_SELECT_ADDR;
            end
            if (state == ST_SELWT && io_ack_in) begin
                select_word <= io_rdata_in;
            end
            if (state == ST_LDREQ && buf_ready) begin
                io_rd_out   <= 1'b1;
                io_addr_out <= `IO_PARALLEL_ADDR;
            end
            if (state == ST_LDWT && io_ack_in && byte_mode) begin
                hi_byte <= io_rdata_in[7:0];
                hi_have <= ~hi_have;
            end
            if (push) begin
                word_cnt <= word_cnt + 16'h0001;
            end
        end
    end

    // Boot result outputs.
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            boot_mode_out        <= `MODE_NONE;
            boot_source_addr_out <= 16'h0000;
            warm_entry_addr_out  <= 16'h0000;
            start_addr_out       <= `ROM_RESET_VECTOR;
            start_from_rom_out   <= 1'b0;
            boot_done_out        <= 1'b0;
            boot_error_out       <= 1'b0;
        end else begin
            if (state == ST_START) begin
                start_addr_out     <= `ROM_RESET_VECTOR;
                start_from_rom_out <= !pms_mp;
                if (!pms_mp && !pms_style) begin
                    boot_mode_out <= `MODE_LEGACY;
                end
            end
            if (state == ST_DECODE) begin
                boot_mode_out  <= dec_mode;
                boot_error_out <= (dec_mode == `MODE_NONE);
                if (dec_mode == `MODE_EPROM8 || dec_mode == `MODE_EPROM16) begin
                    boot_source_addr_out <= field_addr;
                end
                if (dec_mode == `MODE_WARM) begin
                    warm_entry_addr_out <= field_addr;
                    start_addr_out      <= field_addr;
                end
            end
            boot_done_out <= (next_state == ST_DONE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read port; unmapped indices read zero.

    always @(posedge core_clk_in) begin
        if (srst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `REG_PROC_MODE_STATUS:
                    reg_rdata_out <= {pms_frdn, 11'h000, pms_style, pms_saram, pms_mp};
                `REG_BOOT_STATUS:
                    reg_rdata_out <= {sel_low, 2'h0, boot_error_out,
                                      boot_done_out, boot_mode_out};
                `REG_BOOT_SELECT:
                    reg_rdata_out <= select_word;
                default:
                    reg_rdata_out <= 16'h0000;
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

endmodule

`default_nettype wire

//--- tb/boot_cfg_asserts.sv
// Concurrent checks on the boot configuration block's ports.
// Assumes it is bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
`include "boot_cfg_regs.vh"
module boot_cfg_asserts (
    // Clock and reset.
    input wire logic        core_clk_in,
    input wire logic        srst_in,
    // Program fetch decode.
    input wire logic        prog_fetch_in,
    input wire logic [15:0] prog_addr_in,
    input wire logic        rom_sel_out,
    input wire logic        ext_prog_sel_out,
    input wire logic        rom_reserved_hit_out,
    input wire logic        alaw_table_hit_out,
    // Loader side.
    input wire logic        io_rd_out,
    input wire logic [15:0] io_addr_out,
    input wire logic        code_valid_out,
    input wire logic        code_ready_in,
    input wire logic [15:0] code_data_out,
    input wire logic        boot_done_out,
    input wire logic [3:0]  boot_mode_out,
    input wire logic [15:0] start_addr_out,
    input wire logic [15:0] warm_entry_addr_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    // A read strobe lasts exactly one cycle.
    sequence s_one_pulse;
        io_rd_out ##1 !io_rd_out;
    endsequence
    // A refused word stays put.
    sequence s_word_held;
        code_valid_out && $stable(code_data_out);
    endsequence
    a_high_ext: assert property (prog_fetch_in && prog_addr_in[15] |=>
        ext_prog_sel_out && !rom_sel_out) else $error("high fetch not external");
    a_test_area: assert property (prog_fetch_in && prog_addr_in[15:8] == 8'h7f |=>
        !rom_sel_out && (rom_reserved_hit_out != ext_prog_sel_out)) else $error("test area");
    a_low_route: assert property (prog_fetch_in && prog_addr_in < 16'h7f00 |=>
        rom_sel_out != ext_prog_sel_out) else $error("low fetch routing");
    a_alaw_rom: assert property (prog_fetch_in && prog_addr_in[15:8] == 8'h04 |=>
        alaw_table_hit_out == rom_sel_out) else $error("alaw table hit");
    a_io_pulse: assert property (io_rd_out |-> s_one_pulse) else $error("read pulse");
    a_par_addr: assert property (io_rd_out && boot_mode_out inside {`MODE_PAR8,
        `MODE_PAR16} |-> io_addr_out == 16'h0001) else $error("parallel address");
    a_word_held: assert property (code_valid_out && !code_ready_in |=> s_word_held)
        else $error("stalled word lost");
    a_warm_start: assert property (boot_done_out && boot_mode_out == `MODE_WARM |->
        start_addr_out == warm_entry_addr_out) else $error("warm start address");
endmodule
bind reset_boot_mode_select boot_cfg_asserts u_chk (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .prog_fetch_in(prog_fetch_in), .rom_sel_out(rom_sel_out),
    .ext_prog_sel_out(ext_prog_sel_out), .rom_reserved_hit_out(rom_reserved_hit_out),
    .alaw_table_hit_out(alaw_table_hit_out), .prog_addr_in(prog_addr_in),
    .io_rd_out(io_rd_out), .code_valid_out(code_valid_out), .code_ready_in(code_ready_in),
    .boot_done_out(boot_done_out), .io_addr_out(io_addr_out), .code_data_out(code_data_out),
    .start_addr_out(start_addr_out), .warm_entry_addr_out(warm_entry_addr_out),
    .boot_mode_out(boot_mode_out));
`default_nettype wire

//--- tb/boot_source_model.sv
// Boot source on the far side of the I/O read bus.
// Assumes one outstanding read at a time; lat_in sets the answer delay.
`timescale 1ns/1ps
`default_nettype none
module boot_source_model (
    // Clock, reset and pacing.
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic [1:0]  lat_in,
    input  wire logic [15:0] sel_word_in,
    // I/O read bus.
    input  wire logic        io_rd_in,
    input  wire logic [15:0] io_addr_in,
    output var  logic [15:0] io_rdata_out,
    output var  logic        io_ack_out
);
    logic        busy;
    logic [1:0]  wait_cnt;
    logic [15:0] addr_q;
    logic [15:0] par_cnt;
    // Takes a read, waits, acks one cycle; the released bus toggles meanwhile.
    always @(posedge clk_in) begin
        io_ack_out <= 1'b0;
        io_rdata_out <= ~io_rdata_out;
        if (srst_in) begin
            busy <= 1'b0;
            par_cnt <= 16'h0000;
            io_rdata_out <= 16'h5a5a;
        end else if (io_rd_in) begin
            busy <= 1'b1;
            wait_cnt <= lat_in;
            addr_q <= io_addr_in;
        end else if (busy && wait_cnt != 2'b00) begin
            wait_cnt <= wait_cnt - 2'b01;
        end else if (busy) begin
            busy <= 1'b0;
            io_ack_out <= 1'b1;
            if (addr_q == 16'h0001) begin
                io_rdata_out <= 16'h1357 + par_cnt * 16'h0203;
                par_cnt <= par_cnt + 16'h0001;
            end else begin
                io_rdata_out <= sel_word_in;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/reset_boot_mode_select_tb.sv
// Self-checking bench for the reset-time boot configuration block.
// Assumes the block, its header, the boot source model and the checker.
`timescale 1ns/1ps
`default_nettype none
`include "boot_cfg_regs.vh"
module reset_boot_mode_select_tb;
    logic        clk, srst, mp, style, wr, rd, fetch, ready, stall, rom_sel, ext_sel, rsv;
    logic        alaw, mulaw, io_rd, io_ack, valid, from_rom, done, err;
    logic [3:0]  raddr, mode;
    logic [1:0]  lat;
    logic [15:0] wdata, rdata, paddr, io_addr, io_data, cdata, src, warm, start, sel;
    logic [15:0] got_q[$];
    logic [7:0]  codes[9];
    integer      seed, error_cnt, checked, cycles, i;
    reset_boot_mode_select #(.LOAD_WORDS(4)) u_dut (.core_clk_in(clk), .srst_in(srst),
        .proc_mode_strap_in(mp), .boot_style_strap_in(style), .reg_addr_in(raddr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .prog_addr_in(paddr), .prog_fetch_in(fetch), .rom_sel_out(rom_sel),
        .ext_prog_sel_out(ext_sel), .rom_reserved_hit_out(rsv), .alaw_table_hit_out(alaw),
        .mulaw_table_hit_out(mulaw), .io_rd_out(io_rd), .io_addr_out(io_addr),
        .io_rdata_in(io_data), .io_ack_in(io_ack), .code_data_out(cdata),
        .code_valid_out(valid), .code_ready_in(ready), .boot_mode_out(mode),
        .boot_source_addr_out(src), .warm_entry_addr_out(warm), .start_addr_out(start),
        .start_from_rom_out(from_rom), .boot_done_out(done), .boot_error_out(err));
    boot_source_model u_src (.clk_in(clk), .srst_in(srst), .lat_in(lat), .sel_word_in(sel),
        .io_rd_in(io_rd), .io_addr_in(io_addr), .io_rdata_out(io_data), .io_ack_out(io_ack));
    // Clock at 25 MHz.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Collects taken words, paces the sink at random and cuts a hang short.
    always @(posedge clk) begin
        if (valid === 1'b1 && ready === 1'b1)
            got_q.push_back(cdata);
        ready <= !stall && ($random(seed) % 4 != 0);
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            error_cnt = error_cnt + 1;
            give_verdict();
        end
    end
    // Prints the verdict and ends the run.
    task automatic give_verdict();
        if (error_cnt == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, got);
        checked = checked + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [3:0] exp_mode(input logic m, s, input logic [7:0] lo);
        if (m)
            return `MODE_NONE;
        if (!s)
            return `MODE_LEGACY;
        if (lo[1:0] != 2'b00)
            return 4'h6 + {2'b00, lo[1:0]};
        if (lo[4])
            return (lo[3:2] == 2'b00) ? `MODE_UART8 : `MODE_NONE;
        return `MODE_SSP8 + {2'b00, lo[3:2]};
    endfunction
    function automatic logic [15:0] exp_word(input logic [3:0] em, input logic [15:0] k);
        logic [15:0] hi, lo;
        hi = 16'h1357 + (k * 16'h0002) * 16'h0203;
        lo = hi + 16'h0203;
        return (em == `MODE_PAR16) ? 16'h1357 + k * 16'h0203 : {hi[7:0], lo[7:0]};
    endfunction
    task automatic reg_op(input logic w, input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        raddr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask
    task automatic fetch_at(input logic [15:0] a);
        @(posedge clk);
        fetch <= 1'b1;
        paddr <= a;
        @(posedge clk);
        fetch <= 1'b0;
        #1;
    endtask
    // One boot from reset with the given straps and select code, then register probes.
    task automatic run(input logic m, s, input logic [7:0] c);
        logic [15:0] r, ea;
        logic [7:0]  mk, lo;
        logic [3:0]  em;
        integer      n;
        r = $random(seed);
        mk = (c[1:0] != 2'b00) ? 8'h03 : 8'h1f;
        lo = (c & mk) | (r[7:0] & ~mk);
        em = exp_mode(m, s, lo);
        ea = {lo[7:2], 10'h000};
        @(posedge clk);
        {mp, style, srst, stall} <= {m, s, 2'b11};
        sel <= {r[15:8], lo};
        lat <= r[9:8];
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        got_q.delete();
        repeat (20) @(posedge clk);
        stall <= 1'b0;
        for (n = 0; n < 3000 && done !== 1'b1; n++)
            @(negedge clk);
        for (n = 0; n < 100 && valid !== 1'b0; n++)
            @(negedge clk);
        chk("mode", {12'h000, em}, {12'h000, mode});
        chk("done_from_rom_error", {13'h0000, 1'b1, !m, !m && s && em == 4'h0},
            {13'h0000, done, from_rom, err});
        chk("start", (em == `MODE_WARM) ? ea : `ROM_RESET_VECTOR, start);
        if (em == `MODE_EPROM8 || em == `MODE_EPROM16)
            chk("source", ea, src);
        if (em == `MODE_WARM)
            chk("entry", ea, warm);
        n = (em == `MODE_PAR8 || em == `MODE_PAR16) ? 4 : 0;
        chk("words", 16'(n), 16'(got_q.size()));
        for (i = 0; i < n && i < got_q.size(); i++)
            chk("word", exp_word(em, 16'(i)), got_q[i]);
        reg_op(1'b0, `REG_PROC_MODE_STATUS, r);
        chk("status", {12'h000, s, 2'b11, m}, rdata);
        fetch_at(`ROM_RESET_VECTOR);
        chk("rom_sel", {15'h0000, !m}, {15'h0000, rom_sel});
        reg_op(1'b1, `REG_PROC_MODE_STATUS, {1'b1, 11'h000, !s, 2'b00, !m});
        reg_op(1'b0, `REG_PROC_MODE_STATUS, 16'h0000);
        chk("status_wr", {1'b1, 11'h000, s, 2'b00, !m}, rdata);
        fetch_at(`ROM_TEST_BASE + {8'h00, r[7:0]});
        chk("reserved", {15'h0000, m}, {15'h0000, rsv});
        fetch_at(`ROM_ALAW_BASE + {8'h00, r[7:0]});
        chk("alaw", {15'h0000, m}, {15'h0000, alaw});
        fetch_at(`ROM_MULAW_BASE + {8'h00, r[7:0]});
        chk("mulaw", {15'h0000, m}, {15'h0000, mulaw});
        reg_op(1'b0, `REG_BOOT_STATUS, 16'h0000);
        chk("boot_status", {(!m && s) ? lo : 8'h00, 2'b00, !m && s && em == 4'h0, 1'b1, em},
            rdata);
        if (!m && s) begin
            reg_op(1'b0, `REG_BOOT_SELECT, 16'h0000);
            chk("select", {r[15:8], lo}, rdata);
        end
        reg_op(1'b0, 4'hf, 16'h0000);
        chk("unmapped", 16'h0000, rdata);
        for (n = 0; n < 6; n++)
            fetch_at(16'($random(seed)));
    endtask
    // Main sequence: microprocessor, legacy, then every enhanced select code.
    initial begin
        seed = 32'hf503;
        {error_cnt, checked, cycles} = {32'd0, 32'd0, 32'd0};
        {srst, mp, style, wr, rd, fetch, ready, stall} = 8'b1000_0001;
        {raddr, wdata, paddr, sel, lat} = 54'h0;
        codes = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h01, 8'h02, 8'h03, 8'h14};
        repeat (2) @(posedge clk);
        run(1'b1, 1'b1, 8'h0c);
        run(1'b0, 1'b0, 8'h0c);
        for (int j = 0; j < 9; j++)
            run(1'b0, 1'b1, codes[j]);
        give_verdict();
    end
endmodule
`default_nettype wire
